// ---- verilog/mcp_pkg.sv ----
package mcp_pkg;

  // Clock and timing
  localparam int CLK_MHZ = 200;
  localparam int SETUP_NS = 10;
  localparam int STROBE_NS = 20;
  localparam int HOLD_LEVEL_NS = 500;
  localparam int HOLD_RESET_A_NS = 2000;
  localparam int HOLD_RESET_B_NS = 3000;
  localparam int SCLK_HALF_NS = 50;
  // Least times, rounded up to whole cycles
  localparam int SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_LEVEL_CYC = (HOLD_LEVEL_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_RESET_A_CYC = (HOLD_RESET_A_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_RESET_B_CYC = (HOLD_RESET_B_NS * CLK_MHZ + 999) / 1000;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam int TYPE_SETTLE_CYC = 3;

  // Array geometry
  localparam int NUM_BLOCKS = 16;
  localparam int ROWS_PER_BLOCK = 48;

  // Array type code of the short-hold waveform; value is arbitrary
  localparam logic [3:0] ARRAY_TYPE_A = 4'h5;

  // Driver output-count select codes
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_PAIR = 2'h1;
  localparam logic [1:0] MODE_QUAD = 2'h2;
  localparam logic [1:0] MODE_GLOBAL = 2'h3;

  // Driver level select codes
  localparam logic [1:0] LVL_BIAS = 2'h0;
  localparam logic [1:0] LVL_OFFSET = 2'h1;
  localparam logic [1:0] LVL_RESET = 2'h2;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_GO = 8'h04;
  localparam logic [7:0] REG_LOADED = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_CMD_TX = 8'h10;
  localparam logic [7:0] REG_CMD_RX = 8'h14;

  // Field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_BLK_LSB = 2;
  localparam int CTRL_RELEASE_BIT = 6;
  localparam int CTRL_SETB_BIT = 7;
  localparam int GO_PULSE_BIT = 0;
  localparam int GO_CMD_BIT = 1;
  localparam int STAT_PULSE_BUSY_BIT = 0;
  localparam int STAT_CMD_BUSY_BIT = 1;
  localparam int STAT_IRQ_BIT = 2;
  localparam int STAT_REFUSED_BIT = 3;
  localparam int STAT_TYPE_LSB = 4;
  localparam int STAT_WAIT_LOAD_BIT = 8;
  localparam int STAT_TYPE_OK_BIT = 9;

  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CMD_TX_RST = 8'h00;
  localparam logic [15:0] LOADED_RST = 16'h0000;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_STROBE,
    ST_HOLD,
    ST_WAIT_LOAD
  } mcp_state_t;

endpackage

// ---- verilog/mcp_cmd_port.sv ----
`timescale 1ns/1ps
`default_nettype none

module mcp_cmd_port (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Byte request
  input wire logic start,
  input wire logic [7:0] tx_byte,
  output logic busy,
  output logic done,
  output logic [7:0] rx_byte,
  // Serial lines, sdi already synchronised
  input wire logic sdi,
  output logic sclk,
  output logic sdo
);
  import mcp_pkg::*;

  typedef struct packed {
    logic [7:0] cnt;
    logic active;
    logic sclk;
    logic sdo;
    logic [7:0] tx;
    logic [7:0] rx;
    logic [2:0] bits;
    logic done;
  } mcp_port_state_t;

  mcp_port_state_t s_reg;
  mcp_port_state_t s_next;
  logic tick;

  assign tick = (s_reg.cnt == 8'(SCLK_HALF_CYC - 1));

  // Clock idles low; data changes on falling edge, sampled on rising edge.
  // The first tick after start gives half a period of data setup.
  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    if (!s_reg.active) begin
      s_next.cnt = 8'h00;
      if (start) begin
        s_next.active = 1'b1;
        s_next.tx = tx_byte;
        s_next.sdo = tx_byte[7];
        s_next.bits = 3'h0;
        s_next.sclk = 1'b0;
      end
    end else begin
      s_next.cnt = tick ? 8'h00 : s_reg.cnt + 8'h01;
      if (tick) begin
        if (!s_reg.sclk) begin
          s_next.sclk = 1'b1;
          s_next.rx = {s_reg.rx[6:0], sdi};
        end else begin
          s_next.sclk = 1'b0;
          if (s_reg.bits == 3'h7) begin
            s_next.active = 1'b0;
            s_next.done = 1'b1;
            s_next.sdo = 1'b0;
          end else begin
            s_next.bits = s_reg.bits + 3'h1;
            s_next.tx = {s_reg.tx[6:0], 1'b0};
            s_next.sdo = s_reg.tx[6];
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign busy = s_reg.active;
  assign done = s_reg.done;
  assign rx_byte = s_reg.rx;
  assign sclk = s_reg.sclk;
  assign sdo = s_reg.sdo;

endmodule

`default_nettype wire

// ---- verilog/mcp_top.sv ----
// Contract
// - Commands to the pulse driver go over one full-duplex, byte-wide synchronous serial port.
// - The port has select, clock, data to driver, data from driver and interrupt request.
// - Select is active low, only while talking; separate selects for sets A and B.
// - Each set gets strobe, 2-bit output count, 2-bit level and 4-bit group address.
// - Controller orders waveform events on mode, level, address and times each with a strobe.
// - Controller detects the array type and picks the matching waveform.
// - A direct pulse starts only after the target blocks are fully loaded.
// - A pulse with release relaxes mirrors first, then latches after the load.
// - The array is handled as 16 blocks of 48 rows.
// - Four pulse modes: single, paired, quad and global.
// - Single mode resets any one block in any order.
// - Paired mode resets even-odd pairs 0-1 up to 14-15 in any order.
// - Quad mode resets groups 0-3 up to 12-15, addressed at random.
// - Global mode needs the whole array loaded, then resets all blocks together.
// - A status flag stands while a mirror reset sequence is in progress.
`timescale 1ns/1ps
`default_nettype none

module mcp_top (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RESET,
  // Avalon-MM slave
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // Array type pins
  input wire logic [3:0] ARRAY_TYPE,
  // Serial command port
  output logic SET_A_PORT_SELECT_N,
  output logic SET_B_PORT_SELECT_N,
  output logic CMD_PORT_CLOCK,
  output logic CMD_PORT_DATA_IN,
  input wire logic CMD_PORT_DATA_OUT,
  input wire logic CMD_PORT_IRQ,
  // Driver control set A
  output logic SET_A_STROBE,
  output logic [1:0] SET_A_MODE,
  output logic [1:0] SET_A_LEVEL,
  output logic [3:0] SET_A_ADDR,
  // Driver control set B
  output logic SET_B_STROBE,
  output logic [1:0] SET_B_MODE,
  output logic [1:0] SET_B_LEVEL,
  output logic [3:0] SET_B_ADDR,
  // Status
  output logic RESET_ACTIVE
);
  import mcp_pkg::*;

  typedef struct packed {
    logic irq_s1;
    logic irq_s2;
    logic sdi_s1;
    logic sdi_s2;
    logic [3:0] type_s1;
    logic [3:0] type_s2;
    logic [3:0] type_cap;
    logic [1:0] type_age;
    logic type_ok;
    logic waitreq;
    logic [31:0] rdata;
    logic [7:0] ctrl;
    logic [7:0] cmd_tx;
    logic [15:0] loaded;
    logic refused;
    logic cmd_go;
    logic cs_a_n;
    logic cs_b_n;
    mcp_state_t st;
    logic [11:0] cnt;
    logic [1:0] lvl;
    logic release_on;
    logic [15:0] target;
    logic [1:0] mode_o;
    logic [3:0] addr_o;
    logic strobe;
    logic active;
  } mcp_top_state_t;

  mcp_top_state_t s_reg;
  mcp_top_state_t s_next;

  logic [1:0] ctrl_mode;
  logic [3:0] ctrl_blk;
  logic [3:0] grp_mask;
  logic [15:0] tmask;
  logic [31:0] wmask;
  logic [31:0] wd;
  logic wr_hit;
  logic rd_take;
  logic go_pulse;
  logic go_cmd;
  logic covered;
  logic [11:0] hold_cyc;
  logic port_busy;
  logic [7:0] port_rx;
  logic port_sclk;
  logic port_sdo;

  assign ctrl_mode = s_reg.ctrl[CTRL_MODE_LSB +: 2];
  assign ctrl_blk = s_reg.ctrl[CTRL_BLK_LSB +: 4];

  // group width per mode; global compares no address bits at all
  always_comb begin
    unique case (ctrl_mode)
      MODE_SINGLE: grp_mask = 4'hF;
      MODE_PAIR: grp_mask = 4'hE;
      MODE_QUAD: grp_mask = 4'hC;
      MODE_GLOBAL: grp_mask = 4'h0;
    endcase
  end

  // one target bit per block of the sixteen
  genvar gi;
  generate
    for (gi = 0; gi < NUM_BLOCKS; gi++) begin : g_target
      assign tmask[gi] = ((4'(gi) & grp_mask) == (ctrl_blk & grp_mask));
    end
  endgenerate

  // Byte lanes gate every write, including set and clear bits
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign wmask[gi*8 +: 8] = {8{AVS_BYTEENABLE[gi]}};
    end
  endgenerate

  assign wd = AVS_WRITEDATA & wmask;
  // A write acts only at the edge where waitrequest is seen low
  assign wr_hit = AVS_WRITE && !s_reg.waitreq;
  assign rd_take = AVS_READ && s_reg.waitreq;
  assign go_pulse = wr_hit && (AVS_ADDRESS == REG_GO) && wd[GO_PULSE_BIT];
  assign go_cmd = wr_hit && (AVS_ADDRESS == REG_GO) && wd[GO_CMD_BIT];
  assign covered = ((s_reg.loaded & s_reg.target) == s_reg.target);

  // reset-level hold chosen by the detected array type
  assign hold_cyc = (s_reg.lvl != LVL_RESET) ? 12'(HOLD_LEVEL_CYC) :
                    (s_reg.type_cap == ARRAY_TYPE_A) ? 12'(HOLD_RESET_A_CYC) : 12'(HOLD_RESET_B_CYC);

  always_comb begin
    s_next = s_reg;
    s_next.cmd_go = 1'b0;

    // Pins from outside pass two flops before use
    s_next.irq_s1 = CMD_PORT_IRQ;
    s_next.irq_s2 = s_reg.irq_s1;
    s_next.sdi_s1 = CMD_PORT_DATA_OUT;
    s_next.sdi_s2 = s_reg.sdi_s1;
    s_next.type_s1 = ARRAY_TYPE;
    s_next.type_s2 = s_reg.type_s1;

    // type captured once, after the synchroniser has settled
    if (!s_reg.type_ok) begin
      if (s_reg.type_age == 2'(TYPE_SETTLE_CYC)) begin
        s_next.type_cap = s_reg.type_s2;
        s_next.type_ok = 1'b1;
      end else begin
        s_next.type_age = s_reg.type_age + 2'h1;
      end
    end

    // Bus answer one cycle after the request, then back to waiting
    s_next.waitreq = !((AVS_READ || AVS_WRITE) && s_reg.waitreq);
    if (rd_take) begin
      s_next.rdata = 32'h0000_0000;
      unique case (AVS_ADDRESS)
        REG_CTRL: s_next.rdata[7:0] = s_reg.ctrl;
        REG_LOADED: s_next.rdata[15:0] = s_reg.loaded;
        REG_STATUS: begin
          // busy bit mirrors the sequence flag
          s_next.rdata[STAT_PULSE_BUSY_BIT] = s_reg.active;
          s_next.rdata[STAT_CMD_BUSY_BIT] = port_busy || s_reg.cmd_go;
          // interrupt request level from the driver
          s_next.rdata[STAT_IRQ_BIT] = s_reg.irq_s2;
          s_next.rdata[STAT_REFUSED_BIT] = s_reg.refused;
          s_next.rdata[STAT_TYPE_LSB +: 4] = s_reg.type_cap;
          s_next.rdata[STAT_WAIT_LOAD_BIT] = (s_reg.st == ST_WAIT_LOAD);
          s_next.rdata[STAT_TYPE_OK_BIT] = s_reg.type_ok;
        end
        REG_CMD_TX: s_next.rdata[7:0] = s_reg.cmd_tx;
        REG_CMD_RX: s_next.rdata[7:0] = port_rx;
        default: s_next.rdata = 32'h0000_0000;
      endcase
    end

    if (wr_hit && AVS_ADDRESS == REG_CTRL) begin
      s_next.ctrl = (s_reg.ctrl & ~wmask[7:0]) | wd[7:0];
    end
    if (wr_hit && AVS_ADDRESS == REG_CMD_TX) begin
      s_next.cmd_tx = (s_reg.cmd_tx & ~wmask[7:0]) | wd[7:0];
    end
    if (wr_hit && AVS_ADDRESS == REG_STATUS && wd[STAT_REFUSED_BIT]) begin
      s_next.refused = 1'b0;
    end

    // one byte per start; a start while busy is refused
    if (go_cmd) begin
      if (port_busy || s_reg.cmd_go) begin
        s_next.refused = 1'b1;
      end else begin
        s_next.cmd_go = 1'b1;
      end
    end
    // select low only for the chosen set while a byte is on the wire
    s_next.cs_a_n = !((port_busy || s_reg.cmd_go) && !s_reg.ctrl[CTRL_SETB_BIT]);
    s_next.cs_b_n = !((port_busy || s_reg.cmd_go) && s_reg.ctrl[CTRL_SETB_BIT]);

    // each event: set lines, wait setup, strobe, hold
    unique case (s_reg.st)
      ST_IDLE: begin
        if (go_pulse) begin
          // direct pulse refused unless every target block is loaded
          if (!s_reg.type_ok || (!s_reg.ctrl[CTRL_RELEASE_BIT] && ((s_reg.loaded & tmask) != tmask))) begin
            s_next.refused = 1'b1;
          end else begin
            // any block or group in any order
            s_next.target = tmask;
            s_next.mode_o = ctrl_mode;
            // pair address has bit 0 cleared; quad address bits 1:0 cleared
            s_next.addr_o = ctrl_blk & grp_mask;
            s_next.release_on = s_reg.ctrl[CTRL_RELEASE_BIT];
            s_next.lvl = LVL_RESET;
            s_next.cnt = 12'h000;
            s_next.active = 1'b1;
            s_next.st = ST_SETUP;
          end
        end
      end
      ST_SETUP: begin
        if (s_reg.cnt == 12'(SETUP_CYC - 1)) begin
          s_next.cnt = 12'h000;
          s_next.strobe = 1'b1;
          s_next.st = ST_STROBE;
        end else begin
          s_next.cnt = s_reg.cnt + 12'h001;
        end
      end
      ST_STROBE: begin
        if (s_reg.cnt == 12'(STROBE_CYC - 1)) begin
          s_next.cnt = 12'h000;
          s_next.strobe = 1'b0;
          s_next.st = ST_HOLD;
        end else begin
          s_next.cnt = s_reg.cnt + 12'h001;
        end
      end
      ST_HOLD: begin
        if (s_reg.cnt >= hold_cyc - 12'h001) begin
          s_next.cnt = 12'h000;
          if (s_reg.lvl == LVL_RESET) begin
            // release relaxes on offset; direct goes straight to bias
            s_next.lvl = s_reg.release_on ? LVL_OFFSET : LVL_BIAS;
            s_next.st = ST_SETUP;
          end else if (s_reg.lvl == LVL_OFFSET) begin
            s_next.st = ST_WAIT_LOAD;
          end else begin
            // loaded data consumed by the reset
            s_next.loaded = s_reg.loaded & ~s_reg.target;
            s_next.active = 1'b0;
            s_next.st = ST_IDLE;
          end
        end else begin
          s_next.cnt = s_reg.cnt + 12'h001;
        end
      end
      ST_WAIT_LOAD: begin
        // latch only once the new data is in
        if (covered) begin
          s_next.lvl = LVL_BIAS;
          s_next.st = ST_SETUP;
        end
      end
    endcase

    // Software marks blocks loaded; a set in the clearing cycle wins
    if (wr_hit && AVS_ADDRESS == REG_LOADED) begin
      s_next.loaded = s_next.loaded | wd[15:0];
    end
    // Refusal raised in the clearing cycle is kept
    if (go_pulse && s_reg.st == ST_IDLE && s_next.st == ST_IDLE) begin
      s_next.refused = 1'b1;
    end
    if (go_pulse && s_reg.st != ST_IDLE) begin
      s_next.refused = 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      s_reg <= '0;
      s_reg.waitreq <= 1'b1;
      s_reg.ctrl <= CTRL_RST;
      s_reg.cmd_tx <= CMD_TX_RST;
      s_reg.loaded <= LOADED_RST;
      s_reg.cs_a_n <= 1'b1;
      s_reg.cs_b_n <= 1'b1;
      s_reg.st <= ST_IDLE;
      s_reg.lvl <= LVL_BIAS;
    end else begin
      s_reg <= s_next;
    end
  end

  // byte shifter on the single shared serial bus
  mcp_cmd_port u_port (
    .clk(CLK_SYS),
    .reset(RESET),
    .start(s_reg.cmd_go),
    .tx_byte(s_reg.cmd_tx),
    .busy(port_busy),
    .done(),
    .rx_byte(port_rx),
    .sdi(s_reg.sdi_s2),
    .sclk(port_sclk),
    .sdo(port_sdo)
  );

  assign AVS_READDATA = s_reg.rdata;
  assign AVS_WAITREQUEST = s_reg.waitreq;
  // six-line port: two selects, clock, two data lines, irq input
  assign SET_A_PORT_SELECT_N = s_reg.cs_a_n;
  assign SET_B_PORT_SELECT_N = s_reg.cs_b_n;
  assign CMD_PORT_CLOCK = port_sclk;
  assign CMD_PORT_DATA_IN = port_sdo;
  // both sets carry the same waveform so either driver position works
  assign SET_A_STROBE = s_reg.strobe;
  assign SET_A_MODE = s_reg.mode_o;
  assign SET_A_LEVEL = s_reg.lvl;
  assign SET_A_ADDR = s_reg.addr_o;
  assign SET_B_STROBE = s_reg.strobe;
  assign SET_B_MODE = s_reg.mode_o;
  assign SET_B_LEVEL = s_reg.lvl;
  assign SET_B_ADDR = s_reg.addr_o;
  assign RESET_ACTIVE = s_reg.active;

endmodule

`default_nettype wire

// ---- tb/mcp_drv_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module mcp_drv_model #(
  parameter logic [7:0] REPLY = 8'hA5,
  parameter int BBM_CYC = 2
) (
  // Clock
  input wire logic clk,
  // Serial command port
  input wire logic select_n,
  input wire logic sclk,
  input wire logic sdi,
  output logic sdo,
  output logic irq,
  input wire logic raise_irq,
  output logic [7:0] rx_byte,
  // Pulse control
  input wire logic strobe,
  input wire logic [1:0] mode,
  input wire logic [1:0] level,
  input wire logic [3:0] addr,
  output logic [31:0] out_lvls,
  output logic [15:0] out_float
);
  import mcp_pkg::*;
  int bit_i = 7;
  logic strb_d = 1'b0;
  logic [15:0] sel;
  initial begin
    sdo = 1'b0;
    rx_byte = 8'h00;
    out_lvls = '0;
    out_float = '0;
  end
  assign irq = raise_irq;
  // shift in on rising clock, MSB first, only while selected
  always @(posedge sclk) if (!select_n) rx_byte <= {rx_byte[6:0], sdi};
  always @(negedge select_n) begin
    bit_i = 7;
    sdo = REPLY[7];
  end
  always @(negedge sclk) if (!select_n && bit_i > 0) begin
    bit_i = bit_i - 1;
    sdo = REPLY[bit_i];
  end
  // Released line flips so a late sample is never mistaken for data
  always @(posedge select_n) sdo = ~sdo;
  always_comb begin
    case (mode)
      MODE_SINGLE: sel = 16'h0001 << addr;
      MODE_PAIR: sel = 16'h0003 << {addr[3:1], 1'b0};
      MODE_QUAD: sel = 16'h000F << {addr[3:2], 2'b00};
      default: sel = 16'hFFFF;
    endcase
  end
  // float on strobe rise, latch level after the delay, hold after
  always @(posedge clk) begin
    strb_d <= strobe;
    if (strobe && !strb_d) begin
      out_float <= out_float | sel;
      repeat (BBM_CYC) @(posedge clk);
      for (int i = 0; i < 16; i++) if (sel[i]) out_lvls[2 * i +: 2] <= level;
      out_float <= '0;
    end
  end
endmodule

`default_nettype wire

// ---- tb/mcp_chk.sv ----
`timescale 1ns/1ps
`default_nettype none

module mcp_chk (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RESET,
  // Watched outputs
  input wire logic SET_A_PORT_SELECT_N,
  input wire logic SET_B_PORT_SELECT_N,
  input wire logic CMD_PORT_CLOCK,
  input wire logic SET_A_STROBE,
  input wire logic [1:0] SET_A_MODE,
  input wire logic [1:0] SET_A_LEVEL,
  input wire logic [3:0] SET_A_ADDR,
  input wire logic SET_B_STROBE,
  input wire logic [1:0] SET_B_MODE,
  input wire logic [1:0] SET_B_LEVEL,
  input wire logic [3:0] SET_B_ADDR,
  input wire logic RESET_ACTIVE
);
  import mcp_pkg::*;
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RESET);

  sel_excl_a: assert property (SET_A_PORT_SELECT_N || SET_B_PORT_SELECT_N)
    else $error("both selects low");
  clk_sel_a: assert property (CMD_PORT_CLOCK |-> !(SET_A_PORT_SELECT_N && SET_B_PORT_SELECT_N))
    else $error("serial clock outside a frame");
  sel_lead_a: assert property ($fell(SET_A_PORT_SELECT_N && SET_B_PORT_SELECT_N) |-> !CMD_PORT_CLOCK [*8])
    else $error("serial clock too soon after select");
  strobe_len_a: assert property ($rose(SET_A_STROBE) |-> SET_A_STROBE [*4] ##1 !SET_A_STROBE)
    else $error("strobe width wrong");
  ab_same_a: assert property ({SET_A_STROBE, SET_A_MODE, SET_A_LEVEL, SET_A_ADDR} ==
    {SET_B_STROBE, SET_B_MODE, SET_B_LEVEL, SET_B_ADDR}) else $error("control sets differ");
  strb_busy_a: assert property (SET_A_STROBE |-> RESET_ACTIVE)
    else $error("strobe without active flag");
  lvl_setup_a: assert property ($rose(SET_A_STROBE) |-> SET_A_LEVEL == $past(SET_A_LEVEL, 2))
    else $error("level changed inside setup");
  lines_held_a: assert property (SET_A_STROBE && $past(SET_A_STROBE) |-> $stable({SET_A_MODE, SET_A_LEVEL, SET_A_ADDR}))
    else $error("lines moved under strobe");
  pair_grp_a: assert property (RESET_ACTIVE && SET_A_MODE == MODE_PAIR |-> !SET_A_ADDR[0])
    else $error("pair address not even");
  quad_grp_a: assert property (RESET_ACTIVE && SET_A_MODE == MODE_QUAD |-> SET_A_ADDR[1:0] == 2'h0)
    else $error("quad address not aligned");
  glob_grp_a: assert property (RESET_ACTIVE && SET_A_MODE == MODE_GLOBAL |-> SET_A_ADDR == 4'h0)
    else $error("global address not zero");
  start_seq_a: assert property ($rose(RESET_ACTIVE) |-> SET_A_LEVEL == LVL_RESET ##2 $rose(SET_A_STROBE))
    else $error("sequence start wrong");
  end_bias_a: assert property ($fell(RESET_ACTIVE) |-> SET_A_LEVEL == LVL_BIAS)
    else $error("sequence did not end at bias");

  cover property ($rose(SET_A_STROBE) && SET_A_LEVEL == LVL_OFFSET);
  cover property ($rose(RESET_ACTIVE) && SET_A_MODE == MODE_GLOBAL);
  cover property ($rose(RESET_ACTIVE) && SET_A_MODE == MODE_QUAD);
  cover property ($fell(SET_B_PORT_SELECT_N));
endmodule

`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb;
  import mcp_pkg::*;
  typedef struct packed {logic [1:0] mode; logic [3:0] blk; logic [3:0] addr;} mcp_row_t;
  logic CLK_SYS = 1'b0;
  logic RESET = 1'b1;
  logic [7:0] AVS_ADDRESS = 8'h00;
  logic AVS_READ = 1'b0;
  logic AVS_WRITE = 1'b0;
  logic [31:0] AVS_WRITEDATA = 32'h0;
  logic [3:0] AVS_BYTEENABLE = 4'hF;
  logic [3:0] ARRAY_TYPE = ARRAY_TYPE_A;
  logic raise_irq = 1'b0;
  logic strb_d = 1'b0;
  logic [31:0] AVS_READDATA, rd, drv_lvls;
  logic AVS_WAITREQUEST, SET_A_PORT_SELECT_N, SET_B_PORT_SELECT_N, CMD_PORT_CLOCK, CMD_PORT_DATA_IN;
  logic CMD_PORT_DATA_OUT, CMD_PORT_IRQ, SET_A_STROBE, SET_B_STROBE, RESET_ACTIVE;
  logic [1:0] SET_A_MODE, SET_A_LEVEL, SET_B_MODE, SET_B_LEVEL;
  logic [3:0] SET_A_ADDR, SET_B_ADDR;
  logic [7:0] drv_rx;
  logic [1:0] lv_q[$];
  int rise_q[$];
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;
  mcp_row_t rows[6] = '{'{MODE_SINGLE, 4'h9, 4'h9}, '{MODE_PAIR, 4'h7, 4'h6}, '{MODE_PAIR, 4'hF, 4'hE},
    '{MODE_QUAD, 4'hE, 4'hC}, '{MODE_QUAD, 4'h3, 4'h0}, '{MODE_GLOBAL, 4'h5, 4'h0}};

  mcp_top u_dut (.*);
  mcp_drv_model u_drv (.clk(CLK_SYS), .select_n(SET_A_PORT_SELECT_N & SET_B_PORT_SELECT_N),
    .sclk(CMD_PORT_CLOCK), .sdi(CMD_PORT_DATA_IN), .sdo(CMD_PORT_DATA_OUT), .irq(CMD_PORT_IRQ),
    .raise_irq(raise_irq), .rx_byte(drv_rx), .strobe(SET_A_STROBE), .mode(SET_A_MODE), .level(SET_A_LEVEL),
    .addr(SET_A_ADDR), .out_lvls(drv_lvls), .out_float());

  initial begin
    forever #2.5 CLK_SYS = ~CLK_SYS;
  end
  // Level and cycle of every strobe rise
  always @(posedge CLK_SYS) begin
    cyc <= cyc + 1;
    strb_d <= SET_A_STROBE;
    if (SET_A_STROBE === 1'b1 && strb_d === 1'b0) begin
      lv_q.push_back(SET_A_LEVEL);
      rise_q.push_back(cyc);
    end
  end

  function automatic logic [15:0] tmask(input logic [1:0] m, input logic [3:0] a);
    case (m)
      MODE_SINGLE: tmask = 16'h0001 << a;
      MODE_PAIR: tmask = 16'h0003 << a;
      MODE_QUAD: tmask = 16'h000F << a;
      default: tmask = 16'hFFFF;
    endcase
  endfunction
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge CLK_SYS);
    AVS_ADDRESS <= a;
    AVS_WRITE <= wr;
    AVS_READ <= !wr;
    AVS_WRITEDATA <= d;
    AVS_BYTEENABLE <= be;
    do begin
      @(posedge CLK_SYS);
      n++;
    end while (AVS_WAITREQUEST !== 1'b0 && n < 20);
    if (n >= 20) begin
      fails++;
      complete_run();
    end
    rd = AVS_READDATA;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'hF);
    check(rd, exp);
  endtask
  task automatic rd_bit(input logic [7:0] a, input int b, input logic exp);
    bus(1'b0, a, 32'h0, 4'hF);
    check(32'(rd[b]), 32'(exp));
  endtask
  task automatic wait_ra(input logic v, input int lim);
    int n;
    n = 0;
    while (RESET_ACTIVE !== v) begin
      @(posedge CLK_SYS);
      n++;
      if (n > lim) begin
        fails++;
        complete_run();
      end
    end
  endtask
  task automatic do_reset;
    @(posedge CLK_SYS);
    RESET <= 1'b1;
    repeat (6) @(posedge CLK_SYS);
    RESET <= 1'b0;
    repeat (10) @(posedge CLK_SYS);
  endtask
  task automatic go;
    lv_q.delete();
    rise_q.delete();
    wr(REG_GO, 32'h1 << GO_PULSE_BIT);
  endtask

  initial begin
    do_reset();
    check(32'({SET_A_PORT_SELECT_N, SET_B_PORT_SELECT_N, SET_A_STROBE, RESET_ACTIVE}), 32'hC);
    rd_chk(REG_STATUS, (32'h1 << STAT_TYPE_OK_BIT) | (32'(ARRAY_TYPE_A) << STAT_TYPE_LSB));
    bus(1'b1, REG_CTRL, 32'hFF, 4'h0);
    rd_chk(REG_CTRL, 32'h0);
    wr(8'h20, 32'hFFFF);
    rd_chk(8'h20, 32'h0);
    // Unloaded direct pulse, then global with one block missing: both refused
    for (int g = 0; g < 2; g++) begin
      wr(REG_LOADED, g ? 32'h7FFF : 32'h0);
      wr(REG_CTRL, g ? 32'(MODE_GLOBAL) : 32'h3 << CTRL_BLK_LSB);
      go();
      repeat (5) @(posedge CLK_SYS);
      check(32'(RESET_ACTIVE), 32'h0);
      rd_bit(REG_STATUS, STAT_REFUSED_BIT, 1'b1);
      wr(REG_STATUS, 32'h1 << STAT_REFUSED_BIT);
    end
    rd_bit(REG_STATUS, STAT_REFUSED_BIT, 1'b0);
    foreach (rows[i]) begin
      wr(REG_LOADED, 32'hFFFF);
      wr(REG_CTRL, 32'(rows[i].mode) | (32'(rows[i].blk) << CTRL_BLK_LSB));
      go();
      wait_ra(1'b1, 10);
      check(32'({SET_A_MODE, SET_A_LEVEL, SET_A_ADDR}), 32'({rows[i].mode, LVL_RESET, rows[i].addr}));
      wait_ra(1'b0, 3000);
      check(32'(lv_q.size()), 32'h2);
      check(32'({lv_q[0], lv_q[1]}), 32'({LVL_RESET, LVL_BIAS}));
      check(32'(rise_q[1] - rise_q[0]), 32'(STROBE_CYC + HOLD_RESET_A_CYC + SETUP_CYC));
      check(32'(drv_lvls[2 * rows[i].addr +: 2]), 32'(LVL_BIAS));
      rd_chk(REG_LOADED, 32'hFFFF & ~32'(tmask(rows[i].mode, rows[i].addr)));
    end
    // Release pulse: nothing loaded, so it parks until the load lands
    wr(REG_CTRL, (32'h1 << CTRL_RELEASE_BIT) | (32'h2 << CTRL_BLK_LSB));
    go();
    wait_ra(1'b1, 10);
    rd = 32'h0;
    for (int n = 0; n < 200 && rd[STAT_WAIT_LOAD_BIT] !== 1'b1; n++) bus(1'b0, REG_STATUS, 32'h0, 4'hF);
    // Parked sequence still counts as busy
    check(32'({rd[STAT_WAIT_LOAD_BIT], rd[STAT_PULSE_BUSY_BIT]}), 32'h3);
    if (rd[STAT_WAIT_LOAD_BIT] !== 1'b1) complete_run();
    check(32'({lv_q[0], lv_q[1]}), 32'({LVL_RESET, LVL_OFFSET}));
    wr(REG_GO, 32'h1 << GO_PULSE_BIT);
    rd_bit(REG_STATUS, STAT_REFUSED_BIT, 1'b1);
    check(32'(RESET_ACTIVE), 32'h1);
    wr(REG_LOADED, 32'h1 << 2);
    wait_ra(1'b0, 1000);
    check(32'(lv_q.size()), 32'h3);
    check(32'(lv_q[2]), 32'(LVL_BIAS));
    for (int s = 0; s < 2; s++) begin
      wr(REG_CTRL, 32'(s) << CTRL_SETB_BIT);
      wr(REG_CMD_TX, 32'h3C + s);
      wr(REG_GO, 32'h1 << GO_CMD_BIT);
      repeat (5) @(posedge CLK_SYS);
      check(32'({SET_A_PORT_SELECT_N, SET_B_PORT_SELECT_N}), s ? 32'h2 : 32'h1);
      rd = 32'hFFFF_FFFF;
      for (int n = 0; n < 100 && rd[STAT_CMD_BUSY_BIT] !== 1'b0; n++) bus(1'b0, REG_STATUS, 32'h0, 4'hF);
      check(32'(rd[STAT_CMD_BUSY_BIT]), 32'h0);
      if (rd[STAT_CMD_BUSY_BIT] !== 1'b0) complete_run();
      check(32'(drv_rx), 32'h3C + s);
      rd_chk(REG_CMD_RX, 32'hA5);
    end
    raise_irq <= 1'b1;
    repeat (4) @(posedge CLK_SYS);
    rd_bit(REG_STATUS, STAT_IRQ_BIT, 1'b1);
    raise_irq <= 1'b0;
    // Other array type takes the longer reset hold
    ARRAY_TYPE <= 4'h0;
    do_reset();
    // Mid-run reset clears flags and recaptures the type
    rd_chk(REG_STATUS, 32'h1 << STAT_TYPE_OK_BIT);
    wr(REG_LOADED, 32'hFFFF);
    wr(REG_CTRL, 32'(MODE_QUAD) | (32'h5 << CTRL_BLK_LSB));
    go();
    wait_ra(1'b1, 10);
    check(32'(SET_A_ADDR), 32'h4);
    wait_ra(1'b0, 3000);
    check(32'(rise_q[1] - rise_q[0]), 32'(STROBE_CYC + HOLD_RESET_B_CYC + SETUP_CYC));
    complete_run();
  end
endmodule

bind mcp_top mcp_chk u_chk (.*);

`default_nettype wire
